// >>> timer_capture_compare_regs.sv
// Purpose: 16-bit timer with wrap limit and two capture/compare/PWM channels
// Assumes: Pins synchronous to clk; byte register port, read data next cycle
// Notes:   ce low freezes every flop, read data included
// Function
// - Reading count high latches count low until count low is read
// - Reset and the counter-reset bit both clear the counter
// - Counter reaching wrap limit sets wrap flag, restarts from zero next tick
// - Wrap-limit high write suppresses wrap flag until low byte written
// - Reset sets every wrap-limit bit
// - Channel flag sets on active edge in capture, on match in compare
// - Flag clears by read-while-set then write 0; new event voids clear
// - Channel interrupt request only while its enable bit is 1
// - Buffered select only on channel 0; disables channel 1 and its pin
// - Mode bit A picks compare or capture; with edge bits 00 presets level
// - Capture edge bits: 01 rising, 10 falling, 11 both
// - Compare edge bits: 01 toggle, 10 clear, 11 set; 00 flag only
// - Edge bits 00 detach the pin; reset clears them
// - Overflow toggle bit toggles pin at overflow in compare mode only
// - Overflow action wins over a coincident compare action
// - Full-duty bit with overflow toggle forces 100%, from next period
// - Channel pair holds captured count or compare value
// - Channel high read in capture blocks captures until low read
// - Channel high write in compare blocks matches until low written
// - Counter reset clears counter and prescaler, self-clears, reads 0
// - Halt bit stops the counter; reset sets it
// - Prescale codes 0..6 divide by 1..64; code 7 takes external clock
// - Buffered mode starts on channel 0 pair, governed by channel 0 control
//
// Decided for this implementation: the plain strobed port.

`timescale 1ns/10ps

module timer_capture_compare_regs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Pins
  input  wire logic       ext_clk_in,
  input  wire logic [1:0] ch_pin_in,
  output logic      [1:0] ch_pin_out,
  output logic      [1:0] ch_pin_oe,
  // Interrupt requests
  output logic      [1:0] ch_irq,
  output logic            wrap_irq
);

  // ----------------------------------------
  // State and per-cycle terms
  // ----------------------------------------
  timer_cc_pkg::state_t q;
  timer_cc_pkg::state_t n;

  // Counter terms
  logic        tick;
  logic        run;
  logic        ovf;
  logic        trst;
  logic [15:0] inc;
  // Channel terms
  logic [15:0] cmpv;
  logic [1:0]  els;
  logic        act;
  logic        bufm;
  logic        capm;
  logic        cmpm;
  logic        hit;
  logic        match;
  logic        full;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Low prescaler bits that must all be one for a divided tick
  function automatic logic [6:0] pmask(input logic [2:0] s);
    logic [7:0] m;
    m = (8'h01 << s) - 8'h01;
    pmask = m[6:0];
  endfunction

  // Per-channel offsets keep the channel loops uniform
  function automatic logic [7:0] ctl_ofs(input int i);
    ctl_ofs = (i == 1) ? timer_cc_pkg::CH1_CTRL_OFS : timer_cc_pkg::CH0_CTRL_OFS;
  endfunction

  function automatic logic [7:0] hi_ofs(input int i);
    hi_ofs = (i == 1) ? timer_cc_pkg::CH1_HI_OFS : timer_cc_pkg::CH0_HI_OFS;
  endfunction

  function automatic logic [7:0] lo_ofs(input int i);
    lo_ofs = (i == 1) ? timer_cc_pkg::CH1_LO_OFS : timer_cc_pkg::CH0_LO_OFS;
  endfunction

  // Mode decode used by bus and event logic alike
  function automatic logic is_cmp(input timer_cc_pkg::state_t s, input int i);
    is_cmp = s.msa[i] | ((i == 0) & s.msb);
  endfunction

  function automatic logic is_cap(input timer_cc_pkg::state_t s, input int i);
    is_cap = ~is_cmp(s, i) & (s.elsb[i] | s.elsa[i]);
  endfunction

  // Level a compare match leaves on the pin; toggle needs the present level
  function automatic logic match_level(input logic [1:0] e, input logic cur);
    if (e == timer_cc_pkg::ELS_TOG) begin
      match_level = ~cur;
    end else if (e == timer_cc_pkg::ELS_SET) begin
      match_level = 1'b1;
    end else begin
      match_level = 1'b0;
    end
  endfunction

  function automatic logic [7:0] ch_byte(input timer_cc_pkg::state_t s, input int i);
    ch_byte = 8'h00;
    ch_byte[timer_cc_pkg::EV_FLAG_BIT]   = s.flag[i];
    ch_byte[timer_cc_pkg::IRQ_EN_BIT]    = s.ie[i];
    ch_byte[timer_cc_pkg::BUF_SEL_BIT]   = (i == 0) & s.msb;
    ch_byte[timer_cc_pkg::CC_SEL_BIT]    = s.msa[i];
    ch_byte[timer_cc_pkg::ELS_HI_BIT]    = s.elsb[i];
    ch_byte[timer_cc_pkg::ELS_LO_BIT]    = s.elsa[i];
    ch_byte[timer_cc_pkg::OVF_TOG_BIT]   = s.tog[i];
    ch_byte[timer_cc_pkg::FULL_DUTY_BIT] = s.maxb[i];
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Bus accesses come first and timer events after them, so an event
  // in the same cycle as a clearing write leaves its flag set
  always_comb begin
    n     = q;
    trst  = 1'b0;
    cmpv  = 16'h0000;
    els   = 2'h0;
    act   = 1'b0;
    bufm  = 1'b0;
    capm  = 1'b0;
    cmpm  = 1'b0;
    hit   = 1'b0;
    match = 1'b0;
    full  = 1'b0;
    n.rdata = 8'h00;

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    // Read data is zero unless a mapped register is read this cycle
    if (rd) begin
      if (addr == timer_cc_pkg::MAIN_CTRL_OFS) begin
        n.rdata[timer_cc_pkg::WRAP_FLAG_BIT] = q.ovf_f;
        n.rdata[timer_cc_pkg::WRAP_IE_BIT]   = q.ovf_ie;
        n.rdata[timer_cc_pkg::HALT_BIT]      = q.halt;
        n.rdata[timer_cc_pkg::PS_LSB+:3]     = q.ps;
        if (q.ovf_f) begin
          n.ovf_arm = 1'b1;
        end
      end else if (addr == timer_cc_pkg::COUNT_HI_OFS) begin
        n.rdata = q.cnt[15:8];
        if (!q.lat_v) begin
          n.cnt_lat = q.cnt[7:0];
          n.lat_v   = 1'b1;
        end
      end else if (addr == timer_cc_pkg::COUNT_LO_OFS) begin
        n.rdata = q.lat_v ? q.cnt_lat : q.cnt[7:0];
        n.lat_v = 1'b0;
      end else if (addr == timer_cc_pkg::WRAP_HI_OFS) begin
        n.rdata = q.wrap[15:8];
      end else if (addr == timer_cc_pkg::WRAP_LO_OFS) begin
        n.rdata = q.wrap[7:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (addr == ctl_ofs(i)) begin
          if (i == 0 || !q.msb) begin
            n.rdata = ch_byte(q, i);
            if (q.flag[i]) begin
              n.arm[i] = 1'b1;
            end
          end
        end else if (addr == hi_ofs(i)) begin
          n.rdata = q.val[i][15:8];
          if (is_cap(q, i)) begin
            n.cap_lock[i] = 1'b1;
          end
        end else if (addr == lo_ofs(i)) begin
          n.rdata = q.val[i][7:0];
          n.cap_lock[i] = 1'b0;
        end
      end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Counter bytes are read-only; writes to them fall through
    if (wr) begin
      if (addr == timer_cc_pkg::MAIN_CTRL_OFS) begin
        if (!wdata[timer_cc_pkg::WRAP_FLAG_BIT] && q.ovf_arm) begin
          n.ovf_f = 1'b0;
        end
        n.ovf_arm = 1'b0;
        n.ovf_ie  = wdata[timer_cc_pkg::WRAP_IE_BIT];
        n.halt    = wdata[timer_cc_pkg::HALT_BIT];
        n.ps      = wdata[timer_cc_pkg::PS_LSB+:3];
        trst      = wdata[timer_cc_pkg::CNT_RST_BIT];
      end else if (addr == timer_cc_pkg::WRAP_HI_OFS) begin
        n.wrap[15:8] = wdata;
        // A half-written limit must not raise a false wrap flag
        n.wrap_lock  = 1'b1;
      end else if (addr == timer_cc_pkg::WRAP_LO_OFS) begin
        n.wrap[7:0] = wdata;
        n.wrap_lock = 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (addr == ctl_ofs(i)) begin
          // Channel 1 control is dead while the pair is linked
          if (i == 0 || !q.msb) begin
            if (!wdata[timer_cc_pkg::EV_FLAG_BIT] && q.arm[i]) begin
              n.flag[i] = 1'b0;
            end
            n.arm[i]  = 1'b0;
            n.ie[i]   = wdata[timer_cc_pkg::IRQ_EN_BIT];
            n.msa[i]  = wdata[timer_cc_pkg::CC_SEL_BIT];
            n.elsb[i] = wdata[timer_cc_pkg::ELS_HI_BIT];
            n.elsa[i] = wdata[timer_cc_pkg::ELS_LO_BIT];
            n.tog[i]  = wdata[timer_cc_pkg::OVF_TOG_BIT];
            n.maxb[i] = wdata[timer_cc_pkg::FULL_DUTY_BIT];
            if (i == 0) begin
              n.msb = wdata[timer_cc_pkg::BUF_SEL_BIT];
            end
          end
        end else if (addr == hi_ofs(i)) begin
          n.val[i][15:8] = wdata;
          if (is_cmp(q, i)) begin
            n.cmp_lock[i] = 1'b1;
          end
        end else if (addr == lo_ofs(i)) begin
          n.val[i][7:0] = wdata;
          n.cmp_lock[i] = 1'b0;
          if (q.msb) begin
            n.pend_v = 1'b1;
            n.pend   = (i == 1);
          end
        end
      end
    end

    // ----------------------------------------
    // Prescaler and counter
    // ----------------------------------------
    // Prescaler free-runs, so a new divide takes effect within one period
    n.ext_prev = ext_clk_in;
    n.pre      = q.pre + 7'h01;
    if (q.ps == timer_cc_pkg::PS_EXT) begin
      tick = ext_clk_in & ~q.ext_prev;
    end else begin
      tick = (q.pre & pmask(q.ps)) == pmask(q.ps);
    end
    run = tick & ~q.halt;
    // Wrap and compare both look at the next count, so events land with it
    inc = (q.cnt == q.wrap) ? timer_cc_pkg::COUNT_RST : q.cnt + 16'h0001;
    ovf = run & (inc == q.wrap);
    if (run) begin
      n.cnt = inc;
    end
    if (trst) begin
      n.cnt = timer_cc_pkg::COUNT_RST;
      n.pre = 7'h00;
    end

    // ----------------------------------------
    // Wrap flag
    // ----------------------------------------
    if (ovf && !q.wrap_lock) begin
      n.ovf_f   = 1'b1;
      n.ovf_arm = 1'b0;
    end
    n.ovf_irq = n.ovf_f & n.ovf_ie;

    // ----------------------------------------
    // Buffered pair select
    // ----------------------------------------
    // Pair switch only at a period edge so a half-written pair never drives
    if (!q.msb) begin
      n.sel    = 1'b0;
      n.pend_v = 1'b0;
    end else if (ovf && q.pend_v) begin
      n.sel    = q.pend;
      n.pend_v = 1'b0;
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (int i = 0; i < 2; i++) begin
      act  = (i == 0) | ~q.msb;
      bufm = (i == 0) & q.msb;
      els  = {q.elsb[i], q.elsa[i]};
      capm = act & is_cap(q, i);
      cmpm = act & is_cmp(q, i);
      cmpv = bufm ? q.val[q.sel] : q.val[i];
      // Edge detect against last cycle's sample, one cycle of latency
      n.pin_prev[i] = ch_pin_in[i];
      hit = ((els[0] & ch_pin_in[i] & ~q.pin_prev[i]) |
             (els[1] & ~ch_pin_in[i] & q.pin_prev[i]));
      match = cmpm & run & (inc == cmpv) & ~q.cmp_lock[i];
      full  = q.max_eff[i] & q.tog[i];
      // A set here overrides any clear made by the bus above
      if (capm && hit && !q.cap_lock[i]) begin
        n.val[i]  = q.cnt;
        n.flag[i] = 1'b1;
        n.arm[i]  = 1'b0;
      end
      if (match) begin
        n.flag[i] = 1'b1;
        n.arm[i]  = 1'b0;
      end
      if (ovf) begin
        n.max_eff[i] = q.maxb[i];
      end
      // Overflow actions are tested first so they win over a match
      n.poe[i] = cmpm & (els != 2'h0);
      if (els == 2'h0) begin
        n.pout[i] = ~q.msa[i];
      end else if (cmpm) begin
        if (ovf && full) begin
          n.pout[i] = (els == timer_cc_pkg::ELS_CLR);
        end else if (ovf && q.tog[i]) begin
          n.pout[i] = ~q.pout[i];
        end else if (match && !full) begin
          n.pout[i] = match_level(els, q.pout[i]);
        end
      end
      // Request is registered with the flag, so both change on one edge
      n.irq[i] = n.flag[i] & n.ie[i] & act;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q      <= '0;
      q.wrap <= timer_cc_pkg::WRAP_RST;
      q.halt <= timer_cc_pkg::HALT_RST;
      // Detached pins show the preset-high level out of reset
      q.pout <= timer_cc_pkg::PIN_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop; no logic stands after q
  assign rdata      = q.rdata;
  assign ch_pin_out = q.pout;
  assign ch_pin_oe  = q.poe;
  assign ch_irq     = q.irq;
  assign wrap_irq   = q.ovf_irq;

endmodule

// >>> timer_cc_pkg.sv
// Purpose: Constants and state type for the capture/compare timer block
// Assumes: Byte-wide register port, one clock
// Notes:   Offsets are byte addresses on the register port

package timer_cc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] MAIN_CTRL_OFS = 8'h20;
  localparam logic [7:0] COUNT_HI_OFS  = 8'h21;
  localparam logic [7:0] COUNT_LO_OFS  = 8'h22;
  localparam logic [7:0] WRAP_HI_OFS   = 8'h23;
  localparam logic [7:0] WRAP_LO_OFS   = 8'h24;
  localparam logic [7:0] CH0_CTRL_OFS  = 8'h25;
  localparam logic [7:0] CH0_HI_OFS    = 8'h26;
  localparam logic [7:0] CH0_LO_OFS    = 8'h27;
  localparam logic [7:0] CH1_CTRL_OFS  = 8'h28;
  localparam logic [7:0] CH1_HI_OFS    = 8'h29;
  localparam logic [7:0] CH1_LO_OFS    = 8'h2a;

  // ----------------------------------------
  // Main control fields
  // ----------------------------------------
  localparam int WRAP_FLAG_BIT = 7;
  localparam int WRAP_IE_BIT   = 6;
  localparam int HALT_BIT      = 5;
  localparam int CNT_RST_BIT   = 4;
  localparam int PS_LSB        = 0;

  // ----------------------------------------
  // Channel control/status fields
  // ----------------------------------------
  localparam int EV_FLAG_BIT   = 7;
  localparam int IRQ_EN_BIT    = 6;
  localparam int BUF_SEL_BIT   = 5;
  localparam int CC_SEL_BIT    = 4;
  localparam int ELS_HI_BIT    = 3;
  localparam int ELS_LO_BIT    = 2;
  localparam int OVF_TOG_BIT   = 1;
  localparam int FULL_DUTY_BIT = 0;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] WRAP_RST  = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic        HALT_RST  = 1'b1;
  localparam logic [2:0]  PS_EXT    = 3'h7;
  localparam logic [1:0]  ELS_TOG   = 2'h1;
  localparam logic [1:0]  ELS_CLR   = 2'h2;
  localparam logic [1:0]  ELS_SET   = 2'h3;
  localparam logic [1:0]  PIN_RST   = 2'h3;

  typedef struct packed {
    logic [15:0]      cnt;
    logic [6:0]       pre;
    logic [15:0]      wrap;
    logic             wrap_lock;
    logic [7:0]       cnt_lat;
    logic             lat_v;
    logic             ovf_f;
    logic             ovf_arm;
    logic             ovf_ie;
    logic             halt;
    logic [2:0]       ps;
    logic             ext_prev;
    logic [1:0]       flag;
    logic [1:0]       arm;
    logic [1:0]       ie;
    logic [1:0]       msa;
    logic [1:0]       elsb;
    logic [1:0]       elsa;
    logic [1:0]       tog;
    logic [1:0]       maxb;
    logic [1:0]       max_eff;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_lock;
    logic [1:0]       pin_prev;
    logic [1:0]       pout;
    logic [1:0]       poe;
    logic [1:0]       irq;
    logic             ovf_irq;
    logic             msb;
    logic [1:0][15:0] val;
    logic             sel;
    logic             pend_v;
    logic             pend;
    logic [7:0]       rdata;
  } state_t;

endpackage

// >>> pin_partner.sv
// Purpose: Far side of the channel and clock pins
// Assumes: Pins carry no pull; the bench commands the far-side levels
// Notes:   The external clock pin stands low unless the bench pulses it
`timescale 1ns/10ps
module pin_partner (
  // Commands from the bench
  input  logic [1:0] drive_lvl,
  input  logic       ext_lvl,
  // Pin wires
  input  logic [1:0] ch_pin_out,
  input  logic [1:0] ch_pin_oe,
  output logic [1:0] ch_pin_in,
  output logic       ext_clk_in
);
  // Where the block drives, the far side yields and the wire shows the block
  assign ch_pin_in  = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & drive_lvl);
  assign ext_clk_in = ext_lvl;
endmodule

// >>> timer_cc_assertions.sv
// Purpose: Port-level assertions for the capture/compare timer
// Assumes: Channel 0 control is shadowed from register writes
// Notes:   Pin checks wait for one settled cycle after a control write
`timescale 1ns/10ps
module timer_cc_checker (
  // Clock and reset
  input logic       clk,
  input logic       resetn,
  input logic       ce,
  // Register port
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic       wr,
  input logic       rd,
  input logic [7:0] rdata,
  // Pins and requests
  input logic [1:0] ch_pin_out,
  input logic [1:0] ch_pin_oe,
  input logic [1:0] ch_irq
);
  logic [7:0] ch0_q;
  logic [7:0] ch0_p;
  logic       st0;
  logic       rd_c1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch0_q <= 8'h00;
      ch0_p <= 8'h00;
    end else if (ce) begin
      ch0_p <= ch0_q;
      if (wr && addr == timer_cc_pkg::CH0_CTRL_OFS) begin
        ch0_q <= wdata;
      end
    end
  end

  // Pins are registered, so they lag a control write by one cycle
  assign st0   = (ch0_q == ch0_p);
  assign rd_c1 = ce && rd && addr == timer_cc_pkg::CH1_CTRL_OFS;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rst_bit_zero: assert property (ce && rd && addr == timer_cc_pkg::MAIN_CTRL_OFS
    |=> !rdata[timer_cc_pkg::CNT_RST_BIT]) else $error("counter reset bit read as one");
  a_ch1_ctrl_hidden: assert property (rd_c1 && ch0_q[5] |=> rdata == 8'h00)
    else $error("channel 1 control visible in buffered mode");
  a_ch1_pin_free: assert property (ch0_q[5] && ch0_p[5] |-> !ch_pin_oe[1])
    else $error("channel 1 pin driven in buffered mode");
  a_pin_detached: assert property (st0 && ch0_q[3:2] == 2'b00 |-> !ch_pin_oe[0])
    else $error("channel 0 pin driven with edge bits clear");
  a_preset_level: assert property (st0 && ch0_q[3:2] == 2'b00 |-> ch_pin_out[0] == !ch0_q[4])
    else $error("channel 0 preset level wrong");
  a_capture_undriven: assert property (st0 && !ch0_q[5] && !ch0_q[4] |-> !ch_pin_oe[0])
    else $error("channel 0 pin driven in capture mode");
  a_compare_drives: assert property (st0 && (ch0_q[5] || ch0_q[4]) && ch0_q[3:2] != 2'b00
    |-> ch_pin_oe[0]) else $error("channel 0 pin not driven in compare mode");
  a_irq_needs_en: assert property (st0 && !ch0_q[6] |-> !ch_irq[0])
    else $error("channel 0 request without enable");

  c_c1_hidden: cover property (rd_c1 && ch0_q[5]);
  c_irq_up: cover property (ch_irq[0]);
  c_pin_driven: cover property (st0 && ch_pin_oe[0] && ch_pin_out[0]);
endmodule

bind timer_capture_compare_regs timer_cc_checker CHK (
  .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .ch_irq(ch_irq)
);

// >>> tb_top.sv
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: ce tied high; pins reach the block through pin_partner
// Notes:   Every bus transfer takes two cycles; tick counts allow for that
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] MAIN = timer_cc_pkg::MAIN_CTRL_OFS, CNTH = timer_cc_pkg::COUNT_HI_OFS,
    CNTL = timer_cc_pkg::COUNT_LO_OFS, C0 = timer_cc_pkg::CH0_CTRL_OFS, C1 = timer_cc_pkg::CH1_CTRL_OFS;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ext_lvl = 1'b0;
  logic       ext_clk;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [1:0] drv = 2'h0;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] ch_irq;
  logic       wrap_irq;
  int         errors = 0;
  int         samples_checked = 0;

  always #2.5 clk = ~clk;

  timer_capture_compare_regs DUT (
    .clk(clk), .resetn(resetn), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_clk_in(ext_clk), .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
    .ch_irq(ch_irq), .wrap_irq(wrap_irq)
  );
  pin_partner PART (
    .drive_lvl(drv), .ext_lvl(ext_lvl), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
    .ch_pin_in(pin_in), .ext_clk_in(ext_clk)
  );

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    chk(got, e);
  endtask

  // Counter runs for exactly n ticks of the divide-by-one clock, then halts
  task automatic run_ticks(input int n);
    wr_reg(MAIN, 8'h00);
    repeat (n - 2) @(posedge clk);
    wr_reg(MAIN, 8'h20);
  endtask

  task automatic pin_edge(input logic lvl, input logic ef, input logic [7:0] ctl);
    @(posedge clk);
    drv[1] <= lvl;
    repeat (3) @(posedge clk);
    rc(C1, {ef, ctl[6:0]});
    wr_reg(C1, ctl);
  endtask

  initial begin
    #50000;
    errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rc(timer_cc_pkg::WRAP_HI_OFS, 8'hff);
    rc(timer_cc_pkg::WRAP_LO_OFS, 8'hff);
    rc(MAIN, 8'h20);
    rc(CNTL, 8'h00);
    rc(C0, 8'h00);
    rc(8'h30, 8'h00);
    wr_reg(MAIN, 8'h30);
    rd_reg(CNTH);
    run_ticks(300);
    rc(CNTH, 8'h01);
    rc(CNTL, 8'h00);
    rc(CNTH, 8'h01);
    rc(CNTL, 8'h2c);
    wr_reg(MAIN, 8'h30);
    rc(MAIN, 8'h20);
    rc(CNTH, 8'h00);
    rc(CNTL, 8'h00);
    wr_reg(timer_cc_pkg::WRAP_LO_OFS, 8'h09);
    wr_reg(timer_cc_pkg::WRAP_HI_OFS, 8'h00);
    run_ticks(13);
    rc(MAIN, 8'h20);
    rc(CNTH, 8'h00);
    rc(CNTL, 8'h03);
    wr_reg(timer_cc_pkg::WRAP_LO_OFS, 8'h09);
    wr_reg(MAIN, 8'h30);
    run_ticks(13);
    rc(MAIN, 8'ha0);
    chk({7'h00, wrap_irq}, 8'h00);
    wr_reg(MAIN, 8'he0);
    rc(MAIN, 8'he0);
    chk({7'h00, wrap_irq}, 8'h01);
    wr_reg(MAIN, 8'ha0);
    rc(MAIN, 8'ha0);
    wr_reg(MAIN, 8'h20);
    rc(MAIN, 8'h20);
    wr_reg(MAIN, 8'h30);
    wr_reg(C1, 8'h0c);
    run_ticks(7);
    rd_reg(C1);
    wr_reg(C1, 8'h0c);
    pin_edge(1'b1, 1'b1, 8'h0c);
    rc(timer_cc_pkg::CH1_HI_OFS, 8'h00);
    rc(timer_cc_pkg::CH1_LO_OFS, 8'h07);
    wr_reg(MAIN, 8'h30);
    rd_reg(timer_cc_pkg::CH1_HI_OFS);
    pin_edge(1'b0, 1'b0, 8'h0c);
    rc(timer_cc_pkg::CH1_LO_OFS, 8'h07);
    for (int c = 1; c < 4; c++) begin
      wr_reg(MAIN, 8'h30);
      wr_reg(C1, 8'(c << 2));
      pin_edge(1'b1, c != 2, 8'(c << 2));
      pin_edge(1'b0, c != 1, 8'(c << 2));
    end
    wr_reg(MAIN, 8'h30);
    wr_reg(C0, 8'h5c);
    wr_reg(timer_cc_pkg::CH0_HI_OFS, 8'h00);
    wr_reg(timer_cc_pkg::CH0_LO_OFS, 8'h05);
    run_ticks(8);
    rc(C0, 8'hdc);
    chk({5'h00, ch_irq[0], pin_oe[0], pin_out[0]}, 8'h07);
    wr_reg(C0, 8'hdc);
    rc(C0, 8'hdc);
    wr_reg(C0, 8'h5c);
    rc(C0, 8'h5c);
    chk({7'h00, ch_irq[0]}, 8'h00);
    wr_reg(timer_cc_pkg::CH0_HI_OFS, 8'h00);
    wr_reg(MAIN, 8'h30);
    run_ticks(8);
    rc(C0, 8'h5c);
    wr_reg(MAIN, 8'h30);
    wr_reg(C0, 8'h10);
    rc(C0, 8'h10);
    chk({6'h00, pin_oe[0], pin_out[0]}, 8'h00);
    wr_reg(C0, 8'h24);
    rc(C0, 8'h24);
    rc(C1, 8'h00);
    chk({7'h00, pin_oe[1]}, 8'h00);
    wr_reg(C1, 8'h5c);
    wr_reg(C0, 8'h00);
    rc(C1, 8'h0c);
    wr_reg(MAIN, 8'h30);
    wr_reg(MAIN, 8'h07);
    repeat (5) begin
      @(posedge clk);
      ext_lvl <= 1'b1;
      repeat (2) @(posedge clk);
      ext_lvl <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    wr_reg(MAIN, 8'h27);
    rc(CNTH, 8'h00);
    rc(CNTL, 8'h05);
    print_verdict();
  end
endmodule
